// ### pfc_edge_det.sv
module pfc_edge_det (
  input wire logic clock,
  input wire logic rst,
  pfc_edge_if.det  e
);
  logic prev_r;   // level one cycle ago
  logic prev_nxt;

  // next previous level
  always_comb begin
    prev_nxt = e.level;
  end

  // register the level; starts high so a held-high pin gives no false rise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // edge decode per selected mode
  always_comb begin
    case (e.mode)
      pfc_pkg::PFC_EDGE_RISE: e.event_p = e.level & ~prev_r;
      pfc_pkg::PFC_EDGE_FALL: e.event_p = ~e.level & prev_r;
      pfc_pkg::PFC_EDGE_BOTH: e.event_p = e.level ^ prev_r;
      default:                e.event_p = 1'b0;
    endcase
  end
endmodule // pfc_edge_det

// ### pfc_edge_if.sv
interface pfc_edge_if;
  logic              level; // sampled pin level
  pfc_pkg::pfc_edge_e mode; // edge to detect
  logic              event_p; // one-cycle detect pulse
  modport det (input level, input mode, output event_p);
  modport src (output level, output mode, input event_p);
endinterface

// ### pfc_pin_model.sv
// outside circuitry: resolves each pin from chip drive, bench drive, pull-up
module pfc_pin_model (
  input wire logic            clock,
  input wire logic [9:0][7:0] port_out,
  input wire logic [9:0][7:0] port_oe,
  input wire logic [9:0][7:0] port_pullup_en,
  input wire logic [9:0][7:0] ext_val,
  input wire logic [9:0][7:0] ext_en,
  output logic     [9:0][7:0] port_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_r = 8'h55; // floating pins wander every cycle
  // pattern for undriven, unpulled pins
  always @(posedge clock) float_r <= ~float_r;
  // chip drive wins, then outside drive, then pull-up, else wander
  always_comb begin
    for (int s = 0; s < 10; s++) begin
      port_in[s] = (port_oe[s] & port_out[s]) | (~port_oe[s] & ext_en[s] & ext_val[s])
                 | (~port_oe[s] & ~ext_en[s] & (port_pullup_en[s] | float_r));
    end
  end
endmodule // pfc_pin_model

// ### pfc_pkg.sv
package pfc_pkg;
  // number of port groups and their slot order: p0 p1 p2 p3 p7 p8 p9 p10 p11 p12
  localparam int PFC_NPORT = 10;
  localparam int PFC_P0    = 0;
  localparam int PFC_P2    = 2;
  localparam int PFC_P3    = 3;
  localparam int PFC_P7    = 4;
  localparam int PFC_P8    = 5;

  // register banks, one word per port slot
  localparam logic [5:0]  PFC_BANK_LATCH = 6'h00; // byte 0x000 + 4*slot
  localparam logic [5:0]  PFC_BANK_DIR   = 6'h01; // byte 0x040 + 4*slot
  localparam logic [5:0]  PFC_BANK_PULL  = 6'h02; // byte 0x080 + 4*slot
  localparam logic [5:0]  PFC_BANK_ALT   = 6'h03; // byte 0x0C0 + 4*slot
  // single registers
  localparam logic [11:0] PFC_OFS_PCC    = 12'h100; // processor_clock_control
  localparam logic [11:0] PFC_OFS_MSS    = 12'h104; // memory_size_select
  localparam logic [11:0] PFC_OFS_XRS    = 12'h108; // expansion_ram_size_select
  localparam logic [11:0] PFC_OFS_EDGE   = 12'h10C; // edge select, 2 bits per input
  localparam logic [11:0] PFC_OFS_ISTAT  = 12'h110; // interrupt status, read only
  localparam logic [11:0] PFC_OFS_IEN    = 12'h114; // interrupt enable
  localparam logic [11:0] PFC_OFS_ICLR   = 12'h118; // interrupt clear, write only
  localparam logic [11:0] PFC_OFS_MODE   = 12'h11C; // mode status, read only
  localparam logic [11:0] PFC_OFS_TPIN   = 12'h120; // timer pin source select

  // reset values
  localparam logic [7:0]  PFC_PCC_RST    = 8'h00;
  localparam logic [7:0]  PFC_MSS_RST    = 8'hCF; // 60K program, 1024 high-speed ram
  localparam logic [7:0]  PFC_XRS_RST    = 8'h0A; // 1024 expansion ram
  localparam logic [5:0]  PFC_EDGE_RST   = 6'h00;
  localparam logic [3:0]  PFC_IEN_RST    = 4'h0;

  // field positions
  localparam int PFC_FRC_BIT     = 6; // feedback_resistor_cut in pcc
  localparam int PFC_P0_T16_BIT  = 0;
  localparam int PFC_P0_CNT_BIT  = 3;
  localparam int PFC_P0_XTAL_BIT = 4;
  localparam int PFC_P2_STB_BIT  = 3;
  localparam int PFC_P2_BUSY_BIT = 4;
  localparam int PFC_P3_T16_BIT  = 0;
  localparam int PFC_P3_PCL_BIT  = 5;
  localparam int PFC_P3_BUZ_BIT  = 6;

  // per-slot masks, slot 9 first
  localparam logic [9:0][7:0] PFC_WIDTH_MASK = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03,
                                                8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'h1F};
  localparam logic [9:0][7:0] PFC_DIR_MASK   = {8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00,
                                                8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'h0E};
  localparam logic [9:0][7:0] PFC_FORCE_OUT  = {8'h00, 8'h00, 8'hFF, 8'hFF, 8'h03,
                                                8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [9:0][7:0] PFC_PULL_MASK  = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                                8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h0E};
  localparam logic [9:0][7:0] PFC_ALT_MASK   = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03,
                                                8'h00, 8'h61, 8'h08, 8'h00, 8'h00};
  // first display line carried by each slot
  localparam logic [9:0][5:0] PFC_DISP_BASE  = {6'h1A, 6'h12, 6'h0A, 6'h02, 6'h00,
                                                6'h00, 6'h00, 6'h00, 6'h00, 6'h00};

  // edge selection of one interrupt input
  typedef enum logic [1:0] {PFC_EDGE_OFF, PFC_EDGE_RISE, PFC_EDGE_FALL, PFC_EDGE_BOTH} pfc_edge_e;
endpackage

// ### pfc_top.sv
// Functional notes
// RULE1: port0 middle three bits bidirectional, ends input
// RULE2: ports 0,2,3 pull-ups on inputs by software
// RULE3: software sets feedback cut when crystal pin is port
// RULE4: analog port input mode, no automatic pull-up
// RULE5: five-bit n-channel open-drain port, input at reset
// RULE6: three p-channel output-only ports shared with display
// RULE7: two p-channel bidirectional ports, input at reset
// RULE8: first three interrupts: rising, falling or both
// RULE9: fourth interrupt falling only, shares counter clock
// RULE10: auto transfer strobe out, busy in on port2
// RULE11: timer16 and pwm14 output on port3 bit
// RULE12: programming mode by supply level with reset low
// RULE13: programming pins: enable, read strobe, inhibit, buses
// RULE14: reset gives 60K program, 1024 byte ram
// RULE15: reset gives 1024 byte expansion ram
// RULE16: pin driven only when direction selects output
//
// Decided for this implementation: the register offsets and register access over APB.
module pfc_top (
  input  wire logic             clock,
  input  wire logic             rst,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // port pins, slot order p0 p1 p2 p3 p7 p8 p9 p10 p11 p12
  input  wire logic [9:0][7:0]  port_in,
  output logic      [9:0][7:0]  port_out,
  output logic      [9:0][7:0]  port_oe,
  output logic      [9:0][7:0]  port_pullup_en,
  // alternate sources from peripherals
  input  wire logic [33:0]      display_drive,
  input  wire logic             auto_xfer_strobe_out,
  input  wire logic             timer16_out,
  input  wire logic             pwm14_out,
  input  wire logic             programmable_clock_out,
  input  wire logic             buzzer_out,
  // pin levels toward peripherals
  output logic                  busy_in,
  output logic                  timer16_count_in,
  output logic                  updown_counter_clock_in,
  output logic                  sub_crystal_in,
  output logic [7:0]            analog_in_0,
  // configuration toward the rest of the chip
  output logic                  feedback_resistor_cut,
  output logic [7:0]            memory_size_select,
  output logic [7:0]            expansion_ram_size_select,
  output logic                  irq,
  // programming mode
  input  wire logic             prog_supply_ok,
  input  wire logic             reset_pin_n,
  input  wire logic             chip_enable_n,
  input  wire logic             read_strobe_n,
  input  wire logic             program_inhibit_in_n,
  input  wire logic [16:0]      prog_addr,
  input  wire logic [7:0]       prog_data_in,
  output logic      [7:0]       prog_data_out,
  output logic                  prog_data_oe,
  output logic                  prog_mode,
  output logic      [16:0]      prom_addr,
  output logic      [7:0]       prom_wdata,
  output logic                  prom_we,
  input  wire logic [7:0]       prom_rdata
);
  // register state
  logic [9:0][7:0] latch_r, latch_nxt;   // output latches
  logic [9:0][7:0] dir_r, dir_nxt;       // 1 = output
  logic [9:0][7:0] pull_r, pull_nxt;     // pull-up request
  logic [9:0][7:0] alt_r, alt_nxt;       // alternate function select
  logic [7:0]      pcc_r, pcc_nxt;       // processor_clock_control
  logic [7:0]      mss_r, mss_nxt;       // memory_size_select
  logic [7:0]      xrs_r, xrs_nxt;       // expansion_ram_size_select
  logic [5:0]      edge_r, edge_nxt;     // edge select of inputs 0..2
  logic [3:0]      istat_r, istat_nxt;   // sticky interrupt status
  logic [3:0]      ien_r, ien_nxt;       // interrupt enable
  logic            tpin_r, tpin_nxt;     // 1 = pwm14 on timer pin
  logic [31:0]     rdata_r, rdata_nxt;   // captured read word
  logic            err_r, err_nxt;       // unmapped address seen in setup
  // programming state
  logic            pmode_r, pmode_nxt;
  logic [16:0]     paddr_r, paddr_nxt;
  logic [7:0]      pwd_r, pwd_nxt;
  logic            pwe_r, pwe_nxt;
  logic [7:0]      pdo_r, pdo_nxt;
  // combinational helpers
  logic [9:0][7:0] dir_eff;              // effective direction
  logic [9:0][7:0] alt_val;              // alternate drive values
  logic [9:0][7:0] drive_val;            // value heading for each pin
  logic [9:0][7:0] pin_view;             // value seen on reads
  logic [63:0]     disp_ext;             // display lines, zero padded
  logic [3:0]      irq_ev;               // edge pulses
  logic            setup;                // apb setup cycle
  logic            wr;                   // apb write taking effect
  logic [5:0]      bank;                 // port bank of address
  logic [3:0]      slot;                 // port slot of address

  pfc_edge_if eif [4] ();                // one link per interrupt input

  // interrupt edge detectors
  for (genvar k = 0; k < 4; k++) begin : g_irq
    pfc_edge_det u_det (
      .clock (clock),
      .rst   (rst),
      .e     (eif[k])
    );
    assign eif[k].level = port_in[pfc_pkg::PFC_P0][k];
    if (k < 3) begin : g_sel
      assign eif[k].mode = pfc_pkg::pfc_edge_e'(edge_r[2*k +: 2]); // RULE8
    end else begin : g_fall
      assign eif[k].mode = pfc_pkg::PFC_EDGE_FALL; // RULE9
    end
    assign irq_ev[k] = eif[k].event_p;
  end

  assign disp_ext = {30'h0, display_drive};
  assign setup    = psel & ~penable;
  assign wr       = psel & penable & pwrite;
  assign bank     = paddr[11:6];
  assign slot     = paddr[5:2];

  // pin drive and read view
  always_comb begin
    for (int i = 0; i < pfc_pkg::PFC_NPORT; i++) begin
      dir_eff[i] = (dir_r[i] & pfc_pkg::PFC_DIR_MASK[i]) | pfc_pkg::PFC_FORCE_OUT[i]; // RULE1 RULE6
      for (int b = 0; b < 8; b++) begin
        alt_val[i][b] = disp_ext[6'(pfc_pkg::PFC_DISP_BASE[i] + 6'(b))]; // RULE6 RULE7
      end
    end
    // serial and timer sources on ports 2 and 3
    alt_val[pfc_pkg::PFC_P2] = 8'h00;
    alt_val[pfc_pkg::PFC_P2][pfc_pkg::PFC_P2_STB_BIT] = auto_xfer_strobe_out; // RULE10
    alt_val[pfc_pkg::PFC_P3] = 8'h00;
    alt_val[pfc_pkg::PFC_P3][pfc_pkg::PFC_P3_T16_BIT] = tpin_r ? pwm14_out : timer16_out; // RULE11
    alt_val[pfc_pkg::PFC_P3][pfc_pkg::PFC_P3_PCL_BIT] = programmable_clock_out;
    alt_val[pfc_pkg::PFC_P3][pfc_pkg::PFC_P3_BUZ_BIT] = buzzer_out;
    for (int i = 0; i < pfc_pkg::PFC_NPORT; i++) begin
      drive_val[i] = (alt_r[i] & pfc_pkg::PFC_ALT_MASK[i] & alt_val[i])
                   | (~(alt_r[i] & pfc_pkg::PFC_ALT_MASK[i]) & latch_r[i]);
      pin_view[i]  = ((dir_eff[i] & latch_r[i]) | (~dir_eff[i] & port_in[i]))
                   & pfc_pkg::PFC_WIDTH_MASK[i]; // RULE16
      if (i == pfc_pkg::PFC_P7) begin
        // n-channel open drain: only pulls low
        port_out[i] = 8'h00;
        port_oe[i]  = dir_eff[i] & ~drive_val[i] & pfc_pkg::PFC_WIDTH_MASK[i]; // RULE5
      end else if (i >= pfc_pkg::PFC_P8) begin
        // p-channel open drain: only pulls high
        port_out[i] = pfc_pkg::PFC_WIDTH_MASK[i];
        port_oe[i]  = dir_eff[i] & drive_val[i] & pfc_pkg::PFC_WIDTH_MASK[i]; // RULE6 RULE7
      end else begin
        port_out[i] = drive_val[i] & pfc_pkg::PFC_WIDTH_MASK[i];
        port_oe[i]  = dir_eff[i] & pfc_pkg::PFC_WIDTH_MASK[i]; // RULE16
      end
      // pull-up only on inputs, never switched on by analog use
      port_pullup_en[i] = pull_r[i] & ~dir_eff[i] & pfc_pkg::PFC_PULL_MASK[i]; // RULE2 RULE4
    end
  end

  // pin levels handed to peripherals
  assign busy_in                 = port_in[pfc_pkg::PFC_P2][pfc_pkg::PFC_P2_BUSY_BIT]; // RULE10
  assign timer16_count_in        = port_in[pfc_pkg::PFC_P0][pfc_pkg::PFC_P0_T16_BIT];
  assign updown_counter_clock_in = port_in[pfc_pkg::PFC_P0][pfc_pkg::PFC_P0_CNT_BIT]; // RULE9
  assign sub_crystal_in          = port_in[pfc_pkg::PFC_P0][pfc_pkg::PFC_P0_XTAL_BIT];
  assign analog_in_0             = port_in[1]; // RULE4

  // register file next state
  always_comb begin
    latch_nxt = latch_r;
    dir_nxt   = dir_r;
    pull_nxt  = pull_r;
    alt_nxt   = alt_r;
    pcc_nxt   = pcc_r;
    mss_nxt   = mss_r;
    xrs_nxt   = xrs_r;
    edge_nxt  = edge_r;
    ien_nxt   = ien_r;
    tpin_nxt  = tpin_r;
    istat_nxt = istat_r;
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    // software clear first, so a same-cycle event sets again
    if (wr && paddr == pfc_pkg::PFC_OFS_ICLR) begin
      istat_nxt = istat_nxt & ~pwdata[3:0];
    end
    istat_nxt = istat_nxt | irq_ev; // RULE8 RULE9
    // writes take effect in the access cycle
    if (wr && bank <= pfc_pkg::PFC_BANK_ALT && slot < 4'(pfc_pkg::PFC_NPORT)) begin
      if (bank == pfc_pkg::PFC_BANK_LATCH) begin
        latch_nxt[slot] = pwdata[7:0] & pfc_pkg::PFC_WIDTH_MASK[slot];
      end else if (bank == pfc_pkg::PFC_BANK_DIR) begin
        dir_nxt[slot] = pwdata[7:0] & pfc_pkg::PFC_DIR_MASK[slot]; // RULE1 RULE5 RULE7
      end else if (bank == pfc_pkg::PFC_BANK_PULL) begin
        pull_nxt[slot] = pwdata[7:0] & pfc_pkg::PFC_PULL_MASK[slot]; // RULE2
      end else begin
        alt_nxt[slot] = pwdata[7:0] & pfc_pkg::PFC_ALT_MASK[slot];
      end
    end else if (wr && paddr == pfc_pkg::PFC_OFS_PCC) begin
      pcc_nxt = pwdata[7:0]; // RULE3
    end else if (wr && paddr == pfc_pkg::PFC_OFS_MSS) begin
      mss_nxt = pwdata[7:0]; // RULE14
    end else if (wr && paddr == pfc_pkg::PFC_OFS_XRS) begin
      xrs_nxt = pwdata[7:0]; // RULE15
    end else if (wr && paddr == pfc_pkg::PFC_OFS_EDGE) begin
      edge_nxt = pwdata[5:0]; // RULE8
    end else if (wr && paddr == pfc_pkg::PFC_OFS_IEN) begin
      ien_nxt = pwdata[3:0];
    end else if (wr && paddr == pfc_pkg::PFC_OFS_TPIN) begin
      tpin_nxt = pwdata[0]; // RULE11
    end
    // read data and decode captured in the setup cycle
    if (setup) begin
      rdata_nxt = 32'h0;
      err_nxt   = 1'b0;
      if (bank <= pfc_pkg::PFC_BANK_ALT && slot < 4'(pfc_pkg::PFC_NPORT)) begin
        if (bank == pfc_pkg::PFC_BANK_LATCH) begin
          rdata_nxt[7:0] = pin_view[slot]; // RULE16
        end else if (bank == pfc_pkg::PFC_BANK_DIR) begin
          rdata_nxt[7:0] = dir_eff[slot];
        end else if (bank == pfc_pkg::PFC_BANK_PULL) begin
          rdata_nxt[7:0] = pull_r[slot];
        end else begin
          rdata_nxt[7:0] = alt_r[slot];
        end
      end else if (paddr == pfc_pkg::PFC_OFS_PCC) begin
        rdata_nxt[7:0] = pcc_r;
      end else if (paddr == pfc_pkg::PFC_OFS_MSS) begin
        rdata_nxt[7:0] = mss_r;
      end else if (paddr == pfc_pkg::PFC_OFS_XRS) begin
        rdata_nxt[7:0] = xrs_r;
      end else if (paddr == pfc_pkg::PFC_OFS_EDGE) begin
        rdata_nxt[5:0] = edge_r;
      end else if (paddr == pfc_pkg::PFC_OFS_ISTAT) begin
        rdata_nxt[3:0] = istat_r;
      end else if (paddr == pfc_pkg::PFC_OFS_IEN) begin
        rdata_nxt[3:0] = ien_r;
      end else if (paddr == pfc_pkg::PFC_OFS_ICLR) begin
        rdata_nxt = 32'h0; // write only
      end else if (paddr == pfc_pkg::PFC_OFS_MODE) begin
        rdata_nxt[0] = pmode_r;
      end else if (paddr == pfc_pkg::PFC_OFS_TPIN) begin
        rdata_nxt[0] = tpin_r;
      end else begin
        err_nxt = 1'b1; // unmapped
      end
    end
  end

  // register file
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latch_r <= '0;
      dir_r   <= '0; // RULE5 RULE7
      pull_r  <= '0;
      alt_r   <= '0;
      pcc_r   <= pfc_pkg::PFC_PCC_RST;
      mss_r   <= pfc_pkg::PFC_MSS_RST; // RULE14
      xrs_r   <= pfc_pkg::PFC_XRS_RST; // RULE15
      edge_r  <= pfc_pkg::PFC_EDGE_RST;
      istat_r <= 4'h0;
      ien_r   <= pfc_pkg::PFC_IEN_RST;
      tpin_r  <= 1'b0;
      rdata_r <= 32'h0;
      err_r   <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      dir_r   <= dir_nxt;
      pull_r  <= pull_nxt;
      alt_r   <= alt_nxt;
      pcc_r   <= pcc_nxt;
      mss_r   <= mss_nxt;
      xrs_r   <= xrs_nxt;
      edge_r  <= edge_nxt;
      istat_r <= istat_nxt;
      ien_r   <= ien_nxt;
      tpin_r  <= tpin_nxt;
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
    end
  end

  // apb answer: one access cycle, no wait
  assign pready  = 1'b1;
  assign prdata  = rdata_r;
  assign pslverr = psel & penable & err_r;

  // configuration outputs
  assign feedback_resistor_cut     = pcc_r[pfc_pkg::PFC_FRC_BIT]; // RULE3
  assign memory_size_select        = mss_r;
  assign expansion_ram_size_select = xrs_r;
  assign irq                       = |(istat_r & ien_r);

  // programming mode next state
  always_comb begin
    pmode_nxt = prog_supply_ok & ~reset_pin_n; // RULE12
    paddr_nxt = prog_addr; // RULE13
    pwd_nxt   = prog_data_in;
    // write pulse: program low with read strobe high
    pwe_nxt   = pmode_r & ~program_inhibit_in_n & read_strobe_n; // RULE13
    pdo_nxt   = prom_rdata;
  end

  // programming mode registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pmode_r <= 1'b0;
      paddr_r <= 17'h0;
      pwd_r   <= 8'h00;
      pwe_r   <= 1'b0;
      pdo_r   <= 8'h00;
    end else begin
      pmode_r <= pmode_nxt;
      paddr_r <= paddr_nxt;
      pwd_r   <= pwd_nxt;
      pwe_r   <= pwe_nxt;
      pdo_r   <= pdo_nxt;
    end
  end

  // data bus drives only for read and verify
  assign prog_data_oe  = pmode_r & ~chip_enable_n & ~read_strobe_n & program_inhibit_in_n; // RULE13
  assign prog_data_out = pdo_r;
  assign prog_mode     = pmode_r;
  assign prom_addr     = paddr_r;
  assign prom_wdata    = pwd_r;
  assign prom_we       = pwe_r;
endmodule // pfc_top

// ### pfc_top_assertions.sv
// watches the pin, sizing, interrupt and programming outputs
module pfc_top_assertions (
  input wire logic            clock,
  input wire logic            rst,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [9:0][7:0] port_out,
  input wire logic [9:0][7:0] port_oe,
  input wire logic [9:0][7:0] port_pullup_en,
  input wire logic [7:0]      memory_size_select,
  input wire logic [7:0]      expansion_ram_size_select,
  input wire logic            irq,
  input wire logic            prog_supply_ok,
  input wire logic            reset_pin_n,
  input wire logic            prog_mode,
  input wire logic            prog_data_oe,
  input wire logic [7:0]      prog_data_out,
  input wire logic [7:0]      prom_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // apb write in its access phase
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  mss_reset_a: assert property ($past(rst) |-> memory_size_select == 8'hCF)
    else $error("memory size not at reset value");
  xrs_reset_a: assert property ($past(rst) |-> expansion_ram_size_select == 8'h0A)
    else $error("expansion ram size not at reset value");
  size_hold_a: assert property (!wr_acc |=> $stable({memory_size_select, expansion_ram_size_select}))
    else $error("memory sizing changed without a write");
  p0_ends_a: assert property ((port_oe[0] & 8'hF1) == 8'h00)
    else $error("port 0 end bit driven");
  nch_drive_a: assert property ((port_out[4] & port_oe[4]) == 8'h00 && port_oe[4][7:5] == 3'h0)
    else $error("n-channel port drives high");
  pch_drive_a: assert property ((port_out[9:5] & port_oe[9:5]) == port_oe[9:5])
    else $error("p-channel port drives low");
  pull_input_a: assert property ((port_pullup_en & port_oe) == 80'h0 && port_pullup_en[9:4] == 48'h0)
    else $error("pull-up on output or unsupported pin");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_acc))
    else $error("interrupt dropped without a write");
  prog_entry_a: assert property (!$past(rst) |-> prog_mode == ($past(prog_supply_ok) && !$past(reset_pin_n)))
    else $error("programming mode entry wrong");
  read_data_a: assert property (prog_data_oe && !$past(rst) |-> prog_data_out == $past(prom_rdata))
    else $error("programming read data wrong");
  cover property ($rose(irq));
  cover property ($rose(prog_mode));
  cover property (wr_acc);
endmodule // pfc_top_assertions

bind pfc_top pfc_top_assertions i_pfc_top_assertions (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .port_out(port_out), .port_oe(port_oe),
  .port_pullup_en(port_pullup_en), .memory_size_select(memory_size_select),
  .expansion_ram_size_select(expansion_ram_size_select), .irq(irq),
  .prog_supply_ok(prog_supply_ok), .reset_pin_n(reset_pin_n), .prog_mode(prog_mode),
  .prog_data_oe(prog_data_oe), .prog_data_out(prog_data_out), .prom_rdata(prom_rdata));

// ### pfc_top_tb_top.sv
// register-level bench for the pin-function block
module pfc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, ev, busy_in, timer16_count_in, updown_counter_clock_in, sub_crystal_in;
  logic [9:0][7:0] port_in, port_out, port_oe, port_pullup_en;
  logic [9:0][7:0] ext_val = {48'h0, 8'h0F, 8'h10, 8'h3C, 8'hFF}; // outside pin levels
  logic [9:0][7:0] ext_en = {56'h0, 24'hFFFFFF}; // outside drives ports 0 to 2
  logic [33:0] display_drive = 34'h296; // p8 lines 10, p9 lines A5
  logic auto_xfer_strobe_out = 1'b0, timer16_out = 1'b0, pwm14_out = 1'b1;
  logic [7:0] analog_in_0, memory_size_select, expansion_ram_size_select, prog_data_out, prom_wdata;
  logic feedback_resistor_cut, irq, prog_data_oe, prog_mode, prom_we, program_inhibit_in_n = 1'b1;
  logic prog_supply_ok = 1'b0, reset_pin_n = 1'b1, chip_enable_n = 1'b0, read_strobe_n = 1'b0;
  logic [16:0] prog_addr = 17'h1ABCD, prom_addr;
  logic [7:0] prog_data_in = 8'hC3, prom_rdata = 8'h5A;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  // clock at 100 ns
  always #50 clock = ~clock;
  pfc_top i_pfc_top (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .port_in, .port_out, .port_oe, .port_pullup_en, .display_drive,
    .auto_xfer_strobe_out, .timer16_out, .pwm14_out, .programmable_clock_out(pwm14_out),
    .buzzer_out(pwm14_out), .busy_in, .timer16_count_in, .updown_counter_clock_in, .sub_crystal_in,
    .analog_in_0, .feedback_resistor_cut, .memory_size_select, .expansion_ram_size_select, .irq,
    .prog_supply_ok, .reset_pin_n, .chip_enable_n, .read_strobe_n, .program_inhibit_in_n,
    .prog_addr, .prog_data_in, .prog_data_out, .prog_data_oe, .prog_mode, .prom_addr,
    .prom_wdata, .prom_we, .prom_rdata);
  pfc_pin_model i_pfc_pin_model (.clock, .port_out, .port_oe, .port_pullup_en, .ext_val, .ext_en,
    .port_in);
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rv, exp);
  endtask
  // settle point for combinational outputs
  task automatic look;
    @(negedge clock);
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test;
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd("size", pfc_pkg::PFC_OFS_MSS, 32'hCF);
    rd("xsize", pfc_pkg::PFC_OFS_XRS, 32'h0A);
    rd("dir p7", 12'h050, 32'h00);
    rd("dir p8", 12'h054, 32'h03);
    rd("dir p11", 12'h060, 32'h00);
    done("reset");
    wr(12'h040, 32'hFF);
    rd("dir p0", 12'h040, 32'h0E);
    wr(12'h000, 32'h0A);
    look;
    chk("p0 oe", port_oe[0], 32'h0E);
    chk("p0 out", port_out[0] & 8'h0E, 32'h0A);
    rd("p1 pins", 12'h004, 32'h3C);
    chk("analog", analog_in_0, 32'h3C);
    wr(12'h010, 32'h05);
    wr(12'h050, 32'h1F);
    look;
    chk("p7 oe", port_oe[4], 32'h1A);
    wr(12'h060, 32'hFF);
    wr(12'h020, 32'h0F);
    look;
    chk("p11 oe", port_oe[8], 32'h0F);
    wr(12'h048, 32'h08);
    wr(12'h088, 32'hFF);
    look;
    chk("p2 pull", port_pullup_en[2], 32'hF7);
    wr(pfc_pkg::PFC_OFS_PCC, 32'h40);
    look;
    chk("fb cut", feedback_resistor_cut, 32'h1);
    chk("xtal pin", sub_crystal_in, 32'h1);
    done("ports");
    wr(12'h0C8, 32'h08);
    @(posedge clock) auto_xfer_strobe_out <= 1'b1;
    look;
    chk("strobe", port_out[2][3], 32'h1);
    chk("busy", busy_in, 32'h1);
    wr(12'h04C, 32'h01);
    wr(12'h0CC, 32'h61);
    wr(pfc_pkg::PFC_OFS_TPIN, 32'h01);
    look;
    chk("pwm pin", port_out[3] & 8'h61, 32'h61);
    wr(pfc_pkg::PFC_OFS_TPIN, 32'h00);
    look;
    chk("timer pin", port_out[3] & 8'h61, 32'h60);
    wr(12'h0D4, 32'h03);
    wr(12'h0D8, 32'hFF);
    look;
    chk("p8 oe", port_oe[5], 32'h02);
    chk("p9 oe", port_oe[6], 32'hA5);
    done("alt");
    wr(12'h040, 32'h00);
    wr(pfc_pkg::PFC_OFS_EDGE, 32'h39); // rise, fall, both
    wr(pfc_pkg::PFC_OFS_IEN, 32'h0F);
    wr(pfc_pkg::PFC_OFS_ICLR, 32'h0F);
    rd("stat idle", pfc_pkg::PFC_OFS_ISTAT, 32'h0);
    @(posedge clock) ext_val[0] <= 8'hF0;
    rd("stat fall", pfc_pkg::PFC_OFS_ISTAT, 32'hE);
    chk("irq", irq, 32'h1);
    chk("cnt clk", updown_counter_clock_in, 32'h0);
    chk("t16 in", timer16_count_in, 32'h0);
    wr(pfc_pkg::PFC_OFS_ICLR, 32'h0F);
    @(posedge clock) ext_val[0] <= 8'hFF;
    rd("stat rise", pfc_pkg::PFC_OFS_ISTAT, 32'h5);
    wr(pfc_pkg::PFC_OFS_IEN, 32'h00);
    look;
    chk("irq mask", irq, 32'h0);
    done("irq");
    @(posedge clock) begin
      prog_supply_ok <= 1'b1;
      reset_pin_n <= 1'b0;
    end
    repeat (2) @(posedge clock);
    look;
    chk("prog mode", prog_mode, 32'h1);
    chk("data oe", prog_data_oe, 32'h1);
    chk("data out", prog_data_out, 32'h5A);
    rd("mode reg", pfc_pkg::PFC_OFS_MODE, 32'h1);
    @(posedge clock) begin
      program_inhibit_in_n <= 1'b0;
      read_strobe_n <= 1'b1;
    end
    repeat (2) @(posedge clock);
    look;
    chk("prom we", prom_we, 32'h1);
    chk("prom addr", prom_addr, 32'h1ABCD);
    chk("prom data", prom_wdata, 32'hC3);
    @(posedge clock) prog_supply_ok <= 1'b0;
    repeat (2) @(posedge clock);
    look;
    chk("prog exit", prog_mode, 32'h0);
    done("prog");
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped err", ev, 32'h1);
    chk("unmapped data", rv, 32'h0);
    done("unmapped");
    end_of_test;
  end
endmodule // pfc_top_tb_top
